// *** include/dtc_defines.vh ***
// Purpose: register offsets, field positions, encodings and reset values for dtc
// Assumes: byte addresses on a 32-bit Avalon-MM slave, 8-bit data in the low lane
// Notes: included by bare name by the timer/counter design file; the pin synchroniser does not use it
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// register byte offsets
`define DTC_OFS_MODE 5'h00
`define DTC_OFS_CTRL 5'h04
`define DTC_OFS_LOW_T0 5'h08
`define DTC_OFS_HIGH_T0 5'h0c
`define DTC_OFS_LOW_T1 5'h10
`define DTC_OFS_HIGH_T1 5'h14

// timer control register bit positions
`define DTC_BIT_RUN_T0 4
`define DTC_BIT_OVF_T0 5
`define DTC_BIT_RUN_T1 6
`define DTC_BIT_OVF_T1 7

// timer mode register: timer 0 in the low nibble, timer 1 in the high nibble
`define DTC_MODE_T0_LSB 0
`define DTC_MODE_T1_LSB 4
`define DTC_FLD_MODE_LSB 0
`define DTC_FLD_SRC 2
`define DTC_FLD_GATE 3

// mode select encodings
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// reset values
`define DTC_RST_BYTE 8'h00
`define DTC_RST_WORD 32'h00000000

// peripheral cycle: six core clock periods, divider counts 0 to 5
`define DTC_PER_CLKS 6
`define DTC_DIV_LAST 3'h5

`endif

// *** rtl/dtc_pin_sync.v ***
// Purpose: two-stage synchroniser for the four external timer pins
// Assumes: pins are asynchronous to core_clk_in
// Notes: only the second stage is visible outside this module
`default_nettype none

module dtc_pin_sync (
	// clock and reset
	input wire core_clk_in,
	input wire rst_in,
	// raw pins and synchronised copies
	input wire [3:0] pins_in,
	output wire [3:0] pins_out
);

	reg [3:0] meta_reg;
	reg [3:0] sync_reg;

	// first stage feeds the second stage and nothing else
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			meta_reg <= 4'h0;
			sync_reg <= 4'h0;
		end else begin
			meta_reg <= pins_in;
			sync_reg <= meta_reg;
		end
	end

	assign pins_out = sync_reg;

endmodule

`default_nettype wire

// *** rtl/dtc_timer_counter.v ***
// Purpose: two 16-bit timer/counters behind an Avalon-MM slave with waitrequest
// Assumes: core_clk_in at 10 MHz is the peripheral clock; pins are asynchronous
// Notes: overflow flags double as interrupt request levels
//
// How it works
// - each timer chains a high and a low count byte into a 16-bit counter.
// - run bit set lets the selected source increment the low byte; clear stops.
// - low byte overflow bumps high byte; high byte overflow sets overflow flag.
// - starting the timer leaves both count bytes untouched.
// - count bytes are readable at any time and return the live count.
// - source select picks divided clock (timer) or count pin (counter).
// - timer operation counts once per peripheral cycle of six clocks.
// - counter samples pin once per peripheral cycle, counts high-then-low.
// - edge recognition spans two peripheral cycles, max rate clock over twelve.
// - timer 0 uses mode low nibble and control bits 4 and 5.
// - gate clear means run bit alone enables; gate set adds the gate pin.
// - rollover from all ones to zero sets the flag and requests interrupt.
// - timer 0 has four modes, each as timer or event counter.
// - mode 0 uses low five bits as divide-by-32 prescaler into high byte.
// - mode 2 counts low byte, reloads it from high byte on overflow.
// - mode 3 splits timer 0; high byte counts clock/6 using timer 1 bits.
// - servicing the interrupt request clears the overflow flag.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`default_nettype none
`include "dtc_defines.vh"

module dtc_timer_counter (
	// clock and reset
	input wire core_clk_in,
	input wire rst_in,
	// avalon-mm slave
	input wire [4:0] address_in,
	input wire read_in,
	input wire write_in,
	input wire [31:0] writedata_in,
	input wire [3:0] byteenable_in,
	output wire [31:0] readdata_out,
	output wire waitrequest_out,
	// external pins
	input wire count_pin_t0_in,
	input wire count_pin_t1_in,
	input wire external_gate_pin_t0_in,
	input wire external_gate_pin_t1_in,
	// interrupt service acknowledge, one-cycle pulses
	input wire irq_ack_t0_in,
	input wire irq_ack_t1_in,
	// interrupt requests, levels
	output wire irq_t0_out,
	output wire irq_t1_out
);

	// one counting step for modes 0 to 2: returns {overflow, high, low}
	function [16:0] dtc_step;
		input [1:0] mode;
		input [7:0] high;
		input [7:0] low;
		reg [8:0] lo;
		reg [8:0] hi;
		begin
			lo = 9'h000;
			hi = 9'h000;
			case (mode)
				`DTC_MODE_13BIT: begin
					// prescaler in low five bits; upper three bits left alone
					lo = {4'h0, low[4:0]} + 9'h001;
					hi = {1'b0, high} + {8'h00, lo[5]};
					dtc_step = {hi[8], hi[7:0], low[7:5], lo[4:0]};
				end
				`DTC_MODE_16BIT: begin
					lo = {1'b0, low} + 9'h001;
					hi = {1'b0, high} + {8'h00, lo[8]};
					dtc_step = {hi[8], hi[7:0], lo[7:0]};
				end
				`DTC_MODE_RELOAD: begin
					// high byte is the reload value and is never changed here
					lo = {1'b0, low} + 9'h001;
					dtc_step = {lo[8], high, lo[8] ? high : lo[7:0]};
				end
				default: begin
					dtc_step = {1'b0, high, low};
				end
			endcase
		end
	endfunction

	// synchronised pins: {gate t1, gate t0, count t1, count t0}
	wire [3:0] pin_sync;

	dtc_pin_sync u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.pins_in({external_gate_pin_t1_in, external_gate_pin_t0_in,
			count_pin_t1_in, count_pin_t0_in}),
		.pins_out(pin_sync)
	);

	// state
	reg [7:0] mode_reg;
	reg [7:0] mode_next;
	reg run_bit_t0_reg;
	reg run_bit_t0_next;
	reg run_bit_t1_reg;
	reg run_bit_t1_next;
	reg overflow_flag_t0_reg;
	reg overflow_flag_t0_next;
	reg overflow_flag_t1_reg;
	reg overflow_flag_t1_next;
	reg [7:0] count_low_byte_t0_reg;
	reg [7:0] count_low_byte_t0_next;
	reg [7:0] count_high_byte_t0_reg;
	reg [7:0] count_high_byte_t0_next;
	reg [7:0] count_low_byte_t1_reg;
	reg [7:0] count_low_byte_t1_next;
	reg [7:0] count_high_byte_t1_reg;
	reg [7:0] count_high_byte_t1_next;
	reg [2:0] div_reg;
	reg [2:0] div_next;
	reg [1:0] sample_reg;
	reg [1:0] sample_next;
	reg wait_reg;
	reg wait_next;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;

	// decoded fields
	wire [3:0] cfg_t0 = mode_reg[`DTC_MODE_T0_LSB +: 4];
	wire [3:0] cfg_t1 = mode_reg[`DTC_MODE_T1_LSB +: 4];
	wire [1:0] mode_t0 = cfg_t0[`DTC_FLD_MODE_LSB +: 2];
	wire [1:0] mode_t1 = cfg_t1[`DTC_FLD_MODE_LSB +: 2];
	wire split_t0 = (mode_t0 == `DTC_MODE_SPLIT);

	// peripheral cycle strobe, one clock in six
	wire tick = (div_reg == `DTC_DIV_LAST);

	// falling edge: high at the previous peripheral sample, low at this one
	wire edge_t0 = tick & sample_reg[0] & ~pin_sync[0];
	wire edge_t1 = tick & sample_reg[1] & ~pin_sync[1];

	// count event from the selected source
	wire event_t0 = cfg_t0[`DTC_FLD_SRC] ? edge_t0 : tick;
	wire event_t1 = cfg_t1[`DTC_FLD_SRC] ? edge_t1 : tick;

	// gating: gate clear needs run bit only, gate set also needs the pin high
	wire en_t0 = run_bit_t0_reg & (~cfg_t0[`DTC_FLD_GATE] | pin_sync[2]);
	// while timer 0 is split, timer 1 loses its run bit and runs on gating alone
	wire run_t1 = split_t0 ? 1'b1 : run_bit_t1_reg;
	wire en_t1 = run_t1 & (~cfg_t1[`DTC_FLD_GATE] | pin_sync[3]);

	wire step_t0 = en_t0 & event_t0;
	wire step_t1 = en_t1 & event_t1 & (mode_t1 != `DTC_MODE_SPLIT);

	// next counts for each timer in its plain modes
	wire [16:0] res_t0 = dtc_step(mode_t0, count_high_byte_t0_reg, count_low_byte_t0_reg);
	wire [16:0] res_t1 = dtc_step(mode_t1, count_high_byte_t1_reg, count_low_byte_t1_reg);

	// split mode: two independent 8-bit counters
	wire [8:0] split_lo = {1'b0, count_low_byte_t0_reg} + 9'h001;
	wire [8:0] split_hi = {1'b0, count_high_byte_t0_reg} + 9'h001;
	wire split_hi_step = split_t0 & run_bit_t1_reg & tick;

	// bus decode; a write takes effect only in the answer cycle
	wire req = read_in | write_in;
	wire wr = write_in & ~wait_reg & byteenable_in[0];
	wire [7:0] wbyte = writedata_in[7:0];
	wire wr_mode = wr & (address_in == `DTC_OFS_MODE);
	wire wr_ctrl = wr & (address_in == `DTC_OFS_CTRL);
	wire wr_low_t0 = wr & (address_in == `DTC_OFS_LOW_T0);
	wire wr_high_t0 = wr & (address_in == `DTC_OFS_HIGH_T0);
	wire wr_low_t1 = wr & (address_in == `DTC_OFS_LOW_T1);
	wire wr_high_t1 = wr & (address_in == `DTC_OFS_HIGH_T1);

	// overflow events
	reg set_t0;
	reg set_t1;

	// counting, register writes and flag updates
	always @* begin
		mode_next = mode_reg;
		run_bit_t0_next = run_bit_t0_reg;
		run_bit_t1_next = run_bit_t1_reg;
		count_low_byte_t0_next = count_low_byte_t0_reg;
		count_high_byte_t0_next = count_high_byte_t0_reg;
		count_low_byte_t1_next = count_low_byte_t1_reg;
		count_high_byte_t1_next = count_high_byte_t1_reg;
		set_t0 = 1'b0;
		set_t1 = 1'b0;
		div_next = tick ? 3'h0 : div_reg + 3'h1;
		sample_next = tick ? pin_sync[1:0] : sample_reg;

		// timer 0, four modes
		if (split_t0) begin
			if (step_t0) begin
				count_low_byte_t0_next = split_lo[7:0];
				set_t0 = split_lo[8];
			end
			// high half is locked to timer operation and flags through timer 1
			if (split_hi_step) begin
				count_high_byte_t0_next = split_hi[7:0];
				set_t1 = split_hi[8];
			end
		end else if (step_t0) begin
			count_high_byte_t0_next = res_t0[15:8];
			count_low_byte_t0_next = res_t0[7:0];
			set_t0 = res_t0[16];
		end

		// timer 1: split mode holds the count
		if (step_t1) begin
			count_high_byte_t1_next = res_t1[15:8];
			count_low_byte_t1_next = res_t1[7:0];
			if (!split_t0) begin
				set_t1 = res_t1[16];
			end
		end

		// software writes; starting a timer never touches the count
		if (wr_mode) begin
			mode_next = wbyte;
		end
		if (wr_ctrl) begin
			run_bit_t0_next = wbyte[`DTC_BIT_RUN_T0];
			run_bit_t1_next = wbyte[`DTC_BIT_RUN_T1];
		end
		// presets win over counting; presetting a running timer is the user's risk
		if (wr_low_t0) begin
			count_low_byte_t0_next = wbyte;
		end
		if (wr_high_t0) begin
			count_high_byte_t0_next = wbyte;
		end
		if (wr_low_t1) begin
			count_low_byte_t1_next = wbyte;
		end
		if (wr_high_t1) begin
			count_high_byte_t1_next = wbyte;
		end

		// flags: software write or service clears, a hardware set always wins
		overflow_flag_t0_next = ((wr_ctrl ? wbyte[`DTC_BIT_OVF_T0] : overflow_flag_t0_reg)
			& ~irq_ack_t0_in) | set_t0;
		overflow_flag_t1_next = ((wr_ctrl ? wbyte[`DTC_BIT_OVF_T1] : overflow_flag_t1_reg)
			& ~irq_ack_t1_in) | set_t1;
	end

	// bus handshake: waitrequest idles high, drops for exactly one answer cycle
	always @* begin
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		if (req & wait_reg) begin
			wait_next = 1'b0;
			rdata_next = `DTC_RST_WORD;
			// live values, no snapshot, so a read may see a running count
			case (address_in)
				`DTC_OFS_MODE: begin
					rdata_next[7:0] = mode_reg;
				end
				`DTC_OFS_CTRL: begin
					rdata_next[`DTC_BIT_RUN_T0] = run_bit_t0_reg;
					rdata_next[`DTC_BIT_OVF_T0] = overflow_flag_t0_reg;
					rdata_next[`DTC_BIT_RUN_T1] = run_bit_t1_reg;
					rdata_next[`DTC_BIT_OVF_T1] = overflow_flag_t1_reg;
				end
				`DTC_OFS_LOW_T0: begin
					rdata_next[7:0] = count_low_byte_t0_reg;
				end
				`DTC_OFS_HIGH_T0: begin
					rdata_next[7:0] = count_high_byte_t0_reg;
				end
				`DTC_OFS_LOW_T1: begin
					rdata_next[7:0] = count_low_byte_t1_reg;
				end
				`DTC_OFS_HIGH_T1: begin
					rdata_next[7:0] = count_high_byte_t1_reg;
				end
				default: begin
					rdata_next = `DTC_RST_WORD; // unmapped reads as zero
				end
			endcase
		end
	end

	// all state, synchronous reset
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			mode_reg <= `DTC_RST_BYTE;
			run_bit_t0_reg <= 1'b0;
			run_bit_t1_reg <= 1'b0;
			overflow_flag_t0_reg <= 1'b0;
			overflow_flag_t1_reg <= 1'b0;
			count_low_byte_t0_reg <= `DTC_RST_BYTE;
			count_high_byte_t0_reg <= `DTC_RST_BYTE;
			count_low_byte_t1_reg <= `DTC_RST_BYTE;
			count_high_byte_t1_reg <= `DTC_RST_BYTE;
			div_reg <= 3'h0;
			sample_reg <= 2'h0;
			wait_reg <= 1'b1;
			rdata_reg <= `DTC_RST_WORD;
		end else begin
			mode_reg <= mode_next;
			run_bit_t0_reg <= run_bit_t0_next;
			run_bit_t1_reg <= run_bit_t1_next;
			overflow_flag_t0_reg <= overflow_flag_t0_next;
			overflow_flag_t1_reg <= overflow_flag_t1_next;
			count_low_byte_t0_reg <= count_low_byte_t0_next;
			count_high_byte_t0_reg <= count_high_byte_t0_next;
			count_low_byte_t1_reg <= count_low_byte_t1_next;
			count_high_byte_t1_reg <= count_high_byte_t1_next;
			div_reg <= div_next;
			sample_reg <= sample_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// outputs straight from flip-flops
	assign readdata_out = rdata_reg;
	assign waitrequest_out = wait_reg;
	assign irq_t0_out = overflow_flag_t0_reg;
	assign irq_t1_out = overflow_flag_t1_reg;

endmodule

`default_nettype wire

// *** test/dtc_timer_counter_properties.sv ***
// Purpose: port checker for dtc_timer_counter
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design at the foot of this file
`default_nettype none
module dtc_props (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// bus and interrupt ports
	input wire logic [4:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] readdata_out,
	input wire logic waitrequest_out,
	input wire logic irq_ack_t0_in,
	input wire logic irq_ack_t1_in,
	input wire logic irq_t0_out,
	input wire logic irq_t1_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// software may set or clear flags, so a control write excuses a flag change
	wire ctl_wr = write_in && !waitrequest_out && address_in == 5'h04;
	wire ctl_rd = read_in && !waitrequest_out && address_in == 5'h04;
	a_wait_answer: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
		else $error("bus request not answered");
	a_wait_single: assert property (!waitrequest_out |=> waitrequest_out)
		else $error("answer longer than one cycle");
	a_idle_quiet: assert property (!read_in && !write_in && waitrequest_out |=> waitrequest_out)
		else $error("answer without request");
	a_upper_zero: assert property (readdata_out[31:8] == 24'h0)
		else $error("read data above the byte");
	a_ctrl_low_zero: assert property (ctl_rd |-> readdata_out[3:0] == 4'h0)
		else $error("control low bits not zero");
	a_flag_read: assert property (ctl_rd |-> readdata_out[5] == $past(irq_t0_out)
		&& readdata_out[7] == $past(irq_t1_out))
		else $error("flag bits differ from requests");
	a_flag0_hold: assert property (irq_t0_out && !irq_ack_t0_in && !ctl_wr |=> irq_t0_out)
		else $error("timer 0 request dropped");
	a_flag1_hold: assert property (irq_t1_out && !irq_ack_t1_in && !ctl_wr |=> irq_t1_out)
		else $error("timer 1 request dropped");
	a_flag0_fall: assert property ($fell(irq_t0_out) |-> $past(irq_ack_t0_in) || $past(ctl_wr))
		else $error("timer 0 request cleared without cause");
	c_ovf: cover property ($rose(irq_t0_out));
	c_ack: cover property (irq_ack_t0_in && irq_t0_out);
	c_read: cover property (ctl_rd);
endmodule
bind dtc_timer_counter dtc_props u_props (.core_clk_in, .rst_in, .address_in, .read_in,
	.write_in, .readdata_out, .waitrequest_out, .irq_ack_t0_in, .irq_ack_t1_in, .irq_t0_out,
	.irq_t1_out);
`default_nettype wire

// *** test/dtc_pin_model.sv ***
// Purpose: external source for the count and gate pins
// Assumes: pins change only just after a rising edge
// Notes: count pin idles high so no fall is seen between bursts
`default_nettype none
module dtc_pin_model #(parameter int HOLD = 8) (
	// clock
	input wire logic core_clk_in,
	// pins towards the device
	output logic count_pin_out,
	output logic gate_t0_out,
	output logic gate_t1_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		count_pin_out = 1'b1;
		gate_t0_out = 1'b0;
		gate_t1_out = 1'b0;
	end
	// each level held for more than a peripheral cycle, or it may be missed
	task automatic burst(input int n);
		repeat (n) begin
			@(posedge core_clk_in) count_pin_out <= 1'b0;
			repeat (HOLD) @(posedge core_clk_in);
			count_pin_out <= 1'b1;
			repeat (HOLD) @(posedge core_clk_in);
		end
	endtask
	task automatic gate(input logic g0, input logic g1);
		@(posedge core_clk_in) gate_t0_out <= g0;
		gate_t1_out <= g1;
	endtask
endmodule
`default_nettype wire

// *** test/dtc_timer_counter_test.sv ***
// Purpose: self-checking bench for dtc_timer_counter
// Assumes: 10 MHz clock, one wait cycle per bus access
// Notes: run spans are set by edge distance, so tick counts are exact
`default_nettype none
module dtc_timer_counter_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_in, rst_in, read_in, write_in, ack0, ack1;
	logic [3:0] be;
	logic [4:0] address_in;
	logic [31:0] writedata_in;
	wire logic [31:0] rdata;
	wire logic wreq, irq0, irq1, cnt, g0, g1;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	dtc_timer_counter dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .address_in(address_in),
		.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
		.byteenable_in(be), .readdata_out(rdata), .waitrequest_out(wreq),
		.count_pin_t0_in(cnt), .count_pin_t1_in(cnt), .external_gate_pin_t0_in(g0),
		.external_gate_pin_t1_in(g1), .irq_ack_t0_in(ack0), .irq_ack_t1_in(ack1),
		.irq_t0_out(irq0), .irq_t1_out(irq1));
	dtc_pin_model pm (.core_clk_in(core_clk_in), .count_pin_out(cnt), .gate_t0_out(g0),
		.gate_t1_out(g1));
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	// a hang counts as a mismatch
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus access; an edge first so two calls never drive in one step
	task automatic bus(input logic rw, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge core_clk_in);
		address_in <= a;
		writedata_in <= {24'h0, d};
		read_in <= !rw;
		write_in <= rw;
		do @(posedge core_clk_in); while (wreq !== 1'b0);
		q = rdata;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	// stop first so presets and mode changes are legal
	task automatic setup(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
		wr(5'h04, 8'h00);
		wr(5'h00, m);
		wr(5'h08, lo);
		wr(5'h0c, hi);
		wr(5'h10, lo);
		wr(5'h14, hi);
	endtask
	// run for t ticks: the stop write lands 6*t edges after the run write
	task automatic go(input logic [7:0] c, input int t);
		wr(5'h04, c);
		repeat (6 * t - 3) @(posedge core_clk_in);
	endtask
	task automatic t_reset();
		logic [31:0] d;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00, d);
			chk(d, 32'h0);
		end
		// a write without the low byte lane must leave the count alone
		be <= 4'he;
		wr(5'h08, 8'h5a);
		be <= 4'hf;
		bus(1'b0, 5'h08, 8'h00, d);
		chk(d, 32'h0);
	endtask
	task automatic t_rate();
		logic [31:0] d;
		setup(8'h01, 8'hfb, 8'h12);
		go(8'h10, 10);
		wr(5'h04, 8'h00);
		bus(1'b0, 5'h08, 8'h00, d);
		chk(d, 32'h05);
		bus(1'b0, 5'h0c, 8'h00, d);
		chk(d, 32'h13);
		bus(1'b0, 5'h10, 8'h00, d);
		chk(d, 32'hfb);
	endtask
	task automatic t_ovf();
		logic [31:0] d;
		setup(8'h11, 8'hfe, 8'hff);
		go(8'h50, 3);
		chk({30'h0, irq1, irq0}, 32'h3);
		@(posedge core_clk_in) {ack1, ack0} <= 2'b11;
		@(posedge core_clk_in) {ack1, ack0} <= 2'b00;
		@(posedge core_clk_in);
		chk({30'h0, irq1, irq0}, 32'h0);
		// ack and control read add six edges, one more tick, so the count ends at 02
		bus(1'b0, 5'h04, 8'h00, d);
		chk(d, 32'h50);
		wr(5'h04, 8'h00);
		bus(1'b0, 5'h08, 8'h00, d);
		chk(d, 32'h02);
		bus(1'b0, 5'h0c, 8'h00, d);
		chk(d, 32'h00);
	endtask
	task automatic t_modes();
		logic [31:0] d;
		logic [7:0] xl[4] = '{8'he2, 8'h02, 8'h09, 8'hfe};
		logic [7:0] xh[4] = '{8'h08, 8'h08, 8'h07, 8'h0b};
		logic xi[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			// both timers in the same mode; in split mode timer 1 must hold
			setup(8'(i * 17), 8'hfe, 8'h07);
			go((i == 3) ? 8'h40 : 8'h50, 4);
			chk({30'h0, irq1, irq0}, {30'h0, xi[i], xi[i]});
			wr(5'h04, 8'h00);
			bus(1'b0, 5'h08, 8'h00, d);
			chk(d, {24'h0, xl[i]});
			bus(1'b0, 5'h0c, 8'h00, d);
			chk(d, {24'h0, xh[i]});
			bus(1'b0, 5'h10, 8'h00, d);
			chk(d, {24'h0, (i == 3) ? 8'hfe : xl[i]});
			bus(1'b0, 5'h14, 8'h00, d);
			chk(d, {24'h0, (i == 3) ? 8'h07 : xh[i]});
		end
	endtask
	task automatic t_count();
		logic [31:0] d;
		setup(8'h5d, 8'h00, 8'h00);
		pm.gate(1'b0, 1'b0);
		wr(5'h04, 8'h50);
		pm.burst(3);
		repeat (16) @(posedge core_clk_in);
		pm.gate(1'b1, 1'b0);
		repeat (4) @(posedge core_clk_in);
		pm.burst(3);
		repeat (16) @(posedge core_clk_in);
		wr(5'h04, 8'h00);
		bus(1'b0, 5'h08, 8'h00, d);
		chk(d, 32'h03);
		bus(1'b0, 5'h10, 8'h00, d);
		chk(d, 32'h06);
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		rst_in = 1'b1;
		read_in = 1'b0;
		write_in = 1'b0;
		address_in = 5'h00;
		writedata_in = 32'h0;
		ack0 = 1'b0;
		ack1 = 1'b0;
		be = 4'hf;
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_rate();
		t_ovf();
		t_modes();
		t_count();
		conclude();
	end
endmodule
`default_nettype wire
